// ===== logic/ast_baud_gen.sv
`timescale 1ns/1ps
module ast_baud_gen
	import ast_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic hold,
	input wire logic highSpeed,
	input wire logic [DIV_W-1:0] divisor,
	output logic bitTick
);
	logic [DIV_W-1:0] divCnt_reg;
	logic [5:0] preCnt_reg;
	logic [5:0] preTop;

	assign preTop = highSpeed ? PRESCALE_HIGH : PRESCALE_LOW;

	// Divider restarts from zero on enable so the first bit is a full period
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			divCnt_reg <= '0;
			preCnt_reg <= '0;
			bitTick <= 1'b0;
		end else if (hold) begin
			bitTick <= 1'b0;
		end else begin
			bitTick <= 1'b0;
			if (divCnt_reg == '0) begin
				divCnt_reg <= divisor;
				if (preCnt_reg >= preTop) begin
					preCnt_reg <= '0;
					bitTick <= 1'b1;
				end else begin
					preCnt_reg <= preCnt_reg + 6'h01;
				end
			end else begin
				divCnt_reg <= divCnt_reg - DIV_W'(1);
			end
		end
	end
endmodule

// ===== logic/ast_serial_tx.sv
`timescale 1ns/1ps
module ast_serial_tx
	import ast_pkg::*;
#(
	parameter int DIV_W = 8,
	parameter int LOAD_CLKS = INSTR_CYCLE_CLKS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic sleepMode,
	output logic serialOut,
	output logic serialOe,
	output logic bufEmptyFlag,
	output logic txIrq
);
	// ------------------------------------------------------------
	// Software state
	// ------------------------------------------------------------
	logic nineSel_reg;
	logic transmit_enable_reg;
	logic syncSel_reg;
	logic highSpeed_reg;
	logic ninthVal_reg;
	logic [DIV_W-1:0] divisor_reg;
	logic transmit_interrupt_enable_reg;
	logic [7:0] hold_reg;
	logic holdFull_reg;
	logic flag_reg;
	logic [2:0] loadCnt_reg;
	logic moving_reg;
	logic [7:0] rdData_reg;
	logic out_reg;
	logic oe_reg;
	logic irq_reg;

	logic wrCtrl;
	logic wrHold;
	logic wrDiv;
	logic wrIe;
	logic enNext;
	logic enRise;
	logic asyncOn;
	logic runBase;
	logic loadDone;

	ast_tx_if tx();

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wrCtrl = wrStrobe && hit(addr, OFS_CTRL);
	assign wrHold = wrStrobe && hit(addr, OFS_HOLD);
	assign wrDiv = wrStrobe && hit(addr, OFS_DIV);
	assign wrIe = wrStrobe && hit(addr, OFS_IE);
	assign enNext = wrCtrl ? wrData[BIT_TX_EN] : transmit_enable_reg;
	assign enRise = wrCtrl && wrData[BIT_TX_EN] && !transmit_enable_reg;
	assign asyncOn = transmit_enable_reg && !syncSel_reg;
	assign runBase = asyncOn;
	assign loadDone = moving_reg && (loadCnt_reg == 3'(LOAD_CLKS - 1)) && !sleepMode;

	// ------------------------------------------------------------
	// Control and status register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nineSel_reg <= CTRL_RESET[BIT_NINE_SEL];
			transmit_enable_reg <= CTRL_RESET[BIT_TX_EN];
			syncSel_reg <= CTRL_RESET[BIT_SYNC_SEL];
			highSpeed_reg <= CTRL_RESET[BIT_HIGH_SPEED];
			ninthVal_reg <= CTRL_RESET[BIT_NINTH_VAL];
		end else if (wrCtrl) begin
			nineSel_reg <= wrData[BIT_NINE_SEL];
			transmit_enable_reg <= wrData[BIT_TX_EN];
			syncSel_reg <= wrData[BIT_SYNC_SEL];
			highSpeed_reg <= wrData[BIT_HIGH_SPEED];
			ninthVal_reg <= wrData[BIT_NINTH_VAL];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divisor_reg <= '0;
		end else if (wrDiv) begin
			divisor_reg <= wrData[DIV_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			transmit_interrupt_enable_reg <= 1'b0;
		end else if (wrIe) begin
			transmit_interrupt_enable_reg <= wrData[BIT_TX_IE];
		end
	end

	// ------------------------------------------------------------
	// Holding buffer and transfer
	// ------------------------------------------------------------
	// A write while full overwrites; before loadDone the older character is lost, in the loadDone cycle it still goes to the shifter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_reg <= BYTE_ZERO;
			holdFull_reg <= 1'b0;
		end else if (wrHold) begin
			hold_reg <= wrData;
			holdFull_reg <= 1'b1;
		end else if (loadDone) begin
			holdFull_reg <= 1'b0;
		end
	end

	// Transfer waits for an empty shifter, so a load never cuts a frame short
	always_ff @(posedge clk) begin
		if (!rst_n || !asyncOn) begin
			moving_reg <= 1'b0;
			loadCnt_reg <= 3'h0;
		end else if (sleepMode) begin
			moving_reg <= moving_reg;
		end else if (moving_reg) begin
			if (loadDone) begin
				moving_reg <= 1'b0;
				loadCnt_reg <= 3'h0;
			end else begin
				loadCnt_reg <= loadCnt_reg + 3'h1;
			end
		end else if (holdFull_reg && !wrHold && tx.shiftEmpty) begin
			moving_reg <= 1'b1;
		end
	end

	// Set wins over the clear of a write landing in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
		end else if (enRise || loadDone) begin
			flag_reg <= 1'b1;
		end else if (wrHold) begin
			flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Shifter and baud generator
	// ------------------------------------------------------------
	assign tx.load = loadDone;
	assign tx.loadData = {ninthVal_reg, hold_reg};
	assign tx.nineBit = nineSel_reg;
	assign tx.abort = !asyncOn;

	ast_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.clk(clk),
		.rst_n(rst_n),
		.run(runBase && !tx.shiftEmpty),
		.hold(sleepMode),
		.highSpeed(highSpeed_reg),
		.divisor(divisor_reg),
		.bitTick(tx.bitTick)
	);

	ast_tx_shifter u_shift (
		.clk(clk),
		.rst_n(rst_n),
		.tx(tx)
	);

	// ------------------------------------------------------------
	// Pin and request outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_reg <= 1'b1;
			oe_reg <= 1'b0;
		end else begin
			out_reg <= tx.lineOut;
			oe_reg <= asyncOn && enNext;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= flag_reg && transmit_interrupt_enable_reg;
		end
	end

	assign serialOut = out_reg;
	assign serialOe = oe_reg;
	assign bufEmptyFlag = flag_reg;
	assign txIrq = irq_reg;

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Shift register has no address, so it is never readable
	always_ff @(posedge clk) begin
		if (!rst_n || !rdStrobe) begin
			rdData_reg <= BYTE_ZERO;
		end else begin
			case (addr)
				OFS_CTRL: begin
					rdData_reg <= BYTE_ZERO;
					rdData_reg[BIT_NINE_SEL] <= nineSel_reg;
					rdData_reg[BIT_TX_EN] <= transmit_enable_reg;
					rdData_reg[BIT_SYNC_SEL] <= syncSel_reg;
					rdData_reg[BIT_HIGH_SPEED] <= highSpeed_reg;
					rdData_reg[BIT_SHIFT_EMPTY] <= tx.shiftEmpty;
					rdData_reg[BIT_NINTH_VAL] <= ninthVal_reg;
				end
				OFS_HOLD: begin
					rdData_reg <= hold_reg;
				end
				OFS_DIV: begin
					rdData_reg <= 8'(divisor_reg);
				end
				OFS_FLAG: begin
					rdData_reg <= BYTE_ZERO;
					rdData_reg[BIT_BUF_EMPTY] <= flag_reg;
				end
				OFS_IE: begin
					rdData_reg <= BYTE_ZERO;
					rdData_reg[BIT_TX_IE] <= transmit_interrupt_enable_reg;
				end
				default: begin
					rdData_reg <= BYTE_ZERO;
				end
			endcase
		end
	end

	assign rdData = rdData_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_flag_on_enable: assert property (@(posedge clk) disable iff (!rst_n)
		enRise |=> flag_reg)
		else $error("flag not set by enable");

	a_flag_write_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(wrHold && !enRise && !loadDone) |=> !flag_reg)
		else $error("flag not cleared by buffer write");

	a_flag_sw_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_reg && !wrHold) |=> flag_reg)
		else $error("flag cleared without buffer write");

	a_irq_gated: assert property (@(posedge clk) disable iff (!rst_n)
		txIrq == $past(flag_reg && transmit_interrupt_enable_reg))
		else $error("request not gated by enable");

	a_move_cycle: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(moving_reg) && asyncOn && !sleepMode) ##0 (asyncOn && !sleepMode) [*4] |=> !holdFull_reg || $past(wrHold))
		else $error("transfer did not finish in one instruction cycle");

	a_load_empty: assert property (@(posedge clk) disable iff (!rst_n)
		tx.load |-> tx.shiftEmpty)
		else $error("shifter reloaded while busy");

	a_start_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(tx.load && asyncOn) |=> !tx.shiftEmpty ##0 (tx.lineOut throughout (!tx.bitTick [*1])))
		else $error("line not idle before start bit");

	a_abort_release: assert property (@(posedge clk) disable iff (!rst_n)
		(wrCtrl && !wrData[BIT_TX_EN]) |=> ##1 (!serialOe && tx.shiftEmpty))
		else $error("abort did not release pin");

	a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n)
		sleepMode |=> !tx.bitTick)
		else $error("shift clock during sleep");

	a_sync_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(syncSel_reg && !wrCtrl) |=> (tx.shiftEmpty && !moving_reg))
		else $error("transmitter active with synchronous select");

	a_status_empty: assert property (@(posedge clk) disable iff (!rst_n)
		(rdStrobe && addr == OFS_CTRL) |=> rdData[BIT_SHIFT_EMPTY] == $past(tx.shiftEmpty))
		else $error("shifter-empty status wrong");
endmodule

// ===== logic/ast_tx_shifter.sv
`timescale 1ns/1ps
module ast_tx_shifter
	import ast_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ast_tx_if.shifter tx
);
	logic [10:0] frame_reg;
	logic [3:0] bitsLeft_reg;
	logic busy_reg;
	logic line_reg;

	assign tx.shiftEmpty = !busy_reg;
	assign tx.lineOut = line_reg;

	// Stop bit is held a full period; busy drops on the tick after it
	always_ff @(posedge clk) begin
		if (!rst_n || tx.abort) begin
			frame_reg <= '0;
			bitsLeft_reg <= '0;
			busy_reg <= 1'b0;
			line_reg <= 1'b1;
		end else if (tx.load && !busy_reg) begin
			busy_reg <= 1'b1;
			if (tx.nineBit) begin
				frame_reg <= {1'b1, tx.loadData, 1'b0};
				bitsLeft_reg <= FRAME_BITS_9;
			end else begin
				frame_reg <= {2'b11, tx.loadData[7:0], 1'b0};
				bitsLeft_reg <= FRAME_BITS_8;
			end
		end else if (busy_reg && tx.bitTick) begin
			if (bitsLeft_reg == 4'h0) begin
				busy_reg <= 1'b0;
			end else begin
				line_reg <= frame_reg[0];
				frame_reg <= {1'b1, frame_reg[10:1]};
				bitsLeft_reg <= bitsLeft_reg - 4'h1;
			end
		end
	end
endmodule

// ===== pkg/ast_pkg.sv
package ast_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_HOLD = 3'h1;
	localparam logic [2:0] OFS_DIV = 3'h2;
	localparam logic [2:0] OFS_FLAG = 3'h3;
	localparam logic [2:0] OFS_IE = 3'h4;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_NINE_SEL = 6;
	localparam int BIT_TX_EN = 5;
	localparam int BIT_SYNC_SEL = 4;
	localparam int BIT_HIGH_SPEED = 2;
	localparam int BIT_SHIFT_EMPTY = 1;
	localparam int BIT_NINTH_VAL = 0;
	localparam int BIT_BUF_EMPTY = 4;
	localparam int BIT_TX_IE = 4;
	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h02;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [5:0] PRESCALE_HIGH = 6'h0F;
	localparam logic [5:0] PRESCALE_LOW = 6'h3F;
	localparam logic [3:0] FRAME_BITS_8 = 4'hA;
	localparam logic [3:0] FRAME_BITS_9 = 4'hB;
	localparam int CLK_PERIOD_NS = 10;
	localparam int INSTR_CYCLE_NS = 40;
	localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== pkg/ast_tx_if.sv
`timescale 1ns/1ps
interface ast_tx_if;
	logic load;
	logic [8:0] loadData;
	logic nineBit;
	logic abort;
	logic bitTick;
	logic shiftEmpty;
	logic lineOut;
	modport ctrl (
		output load,
		output loadData,
		output nineBit,
		output abort,
		output bitTick,
		input shiftEmpty,
		input lineOut
	);
	modport shifter (
		input load,
		input loadData,
		input nineBit,
		input abort,
		input bitTick,
		output shiftEmpty,
		output lineOut
	);
endinterface

// ===== tb/ast_rx_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------
// Remote receiver on the transmit line
// --------------------------------------------------------
module ast_rx_model (
	input wire logic clk,
	input wire logic lineIn,
	input wire logic nineBits,
	input wire logic [15:0] bitClks,
	output logic [8:0] rxData,
	output logic rxStop,
	output logic [15:0] lowLen,
	output int rxCount
);
	logic [15:0] run;
	initial begin
		rxData = 9'h000;
		rxStop = 1'b0;
		lowLen = 16'h0000;
		rxCount = 0;
		run = 16'h0000;
	end
	// Length of the last low run, so the start bit of 0xFF gives one bit period
	always @(posedge clk) begin
		if (lineIn === 1'b0) begin
			run <= run + 16'h0001;
		end else begin
			if (run != 16'h0000) begin
				lowLen <= run;
			end
			run <= 16'h0000;
		end
	end
	// Mid-bit sampling; a glitch shorter than half a bit is not a start
	always begin
		@(negedge lineIn);
		repeat (bitClks / 2) @(posedge clk);
		if (lineIn === 1'b0) begin
			for (int i = 0; i < 9; i++) begin
				if (i < 8 || nineBits) begin
					repeat (bitClks) @(posedge clk);
					rxData[i] = lineIn;
				end else begin
					rxData[8] = 1'b0;
				end
			end
			repeat (bitClks) @(posedge clk);
			rxStop = lineIn;
			rxCount++;
		end
	end
endmodule

// ===== tb/async_serial_transmitter_tb.sv
`timescale 1ns/1ps
module async_serial_transmitter_tb
	import ast_pkg::*;
;
	localparam logic [7:0] EN = 8'h01 << BIT_TX_EN;
	localparam logic [7:0] HS = 8'h01 << BIT_HIGH_SPEED;
	localparam logic [7:0] SE = 8'h01 << BIT_SHIFT_EMPTY;
	localparam logic [7:0] NB = (8'h01 << BIT_NINE_SEL) | (8'h01 << BIT_NINTH_VAL);
	logic clk, rst_n, wrStrobe, rdStrobe, sleepMode, serialOut, serialOe, bufEmptyFlag, txIrq, nineBits, rxStop;
	logic [2:0] addr;
	logic [7:0] wrData, rdData, v, snap;
	logic [8:0] rxData;
	logic [15:0] bitClks, lowLen;
	logic lineWire;
	int rxCount, base, miscompares, nCompared;
	logic [7:0] divTab [3] = '{8'h02, 8'h01, 8'h00};
	logic hsTab [3] = '{1'b1, 1'b0, 1'b0};
	// Pull-up on the far side: a released pin reads high
	assign lineWire = serialOe ? serialOut : 1'b1;
	ast_serial_tx dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .sleepMode(sleepMode), .serialOut(serialOut),
		.serialOe(serialOe), .bufEmptyFlag(bufEmptyFlag), .txIrq(txIrq));
	ast_rx_model rx (.clk(clk), .lineIn(lineWire), .nineBits(nineBits), .bitClks(bitClks),
		.rxData(rxData), .rxStop(rxStop), .lowLen(lowLen), .rxCount(rxCount));
	always #5 clk = ~clk;
	// --------------------------------------------------------
	// Bus and check tasks
	// --------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Strobe stays up so back-to-back writes need no gap
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		rdStrobe <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rdStrobe <= 1'b1;
		wrStrobe <= 1'b0;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1 d = rdData;
	endtask
	task automatic cyc(input int n);
		wrStrobe <= 1'b0;
		rdStrobe <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic waitRx(input int n);
		int k;
		k = 0;
		wrStrobe <= 1'b0;
		rdStrobe <= 1'b0;
		while (rxCount < n && k < 4000) begin
			@(posedge clk);
			k++;
		end
		chk("frame count", 16'(rxCount), 16'(n));
	endtask
	task automatic closeOut();
		$display("compared %0d mismatched %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		closeOut();
	end
	// --------------------------------------------------------
	// Tests
	// --------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		addr = 3'h0;
		wrData = 8'h00;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		sleepMode = 1'b0;
		nineBits = 1'b0;
		bitClks = 16'h0010;
		miscompares = 0;
		nCompared = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		chk("oe", serialOe, 1'b0);
		chk("flag", bufEmptyFlag, 1'b0);
		rd(OFS_CTRL, v);
		chk("ctrl", v, CTRL_RESET);
		rd(3'h7, v);
		chk("unmapped", v, 8'h00);
		wr(OFS_CTRL, EN | HS);
		#1 chk("flag", bufEmptyFlag, 1'b1);
		chk("irq", txIrq, 1'b0);
		wr(OFS_FLAG, 8'h00);
		#1 chk("flag", bufEmptyFlag, 1'b1);
		wr(OFS_IE, 8'h01 << BIT_TX_IE);
		cyc(2);
		chk("irq", txIrq, 1'b1);
		wr(OFS_HOLD, 8'hA5);
		#1 chk("flag", bufEmptyFlag, 1'b0);
		cyc(2);
		chk("flag", bufEmptyFlag, 1'b0);
		chk("irq", txIrq, 1'b0);
		cyc(4);
		chk("flag", bufEmptyFlag, 1'b1);
		chk("line", serialOut, 1'b1);
		rd(OFS_CTRL, v);
		chk("empty", v & SE, 8'h00);
		wr(OFS_HOLD, 8'h3C);
		cyc(40);
		chk("flag", bufEmptyFlag, 1'b0);
		waitRx(1);
		chk("data", rxData, 9'h0A5);
		chk("stop", rxStop, 1'b1);
		waitRx(2);
		chk("data", rxData, 9'h03C);
		cyc(16);
		rd(OFS_CTRL, v);
		chk("ctrl", v, EN | HS | SE);
		rd(OFS_HOLD, v);
		chk("hold", v, 8'h3C);
		rd(OFS_FLAG, v);
		chk("flag reg", v, 8'h01 << BIT_BUF_EMPTY);
		rd(OFS_IE, v);
		chk("ie reg", v, 8'h01 << BIT_TX_IE);
		rd(OFS_DIV, v);
		chk("divisor", v, 8'h00);
		for (int i = 0; i < 3; i++) begin
			cyc(200);
			base = rxCount;
			bitClks = 16'((divTab[i] + 1) * (hsTab[i] ? 16 : 64));
			wr(OFS_DIV, divTab[i]);
			wr(OFS_CTRL, EN | (hsTab[i] ? HS : 8'h00));
			wr(OFS_HOLD, 8'hFF);
			waitRx(base + 1);
			chk("bit period", lowLen, bitClks);
			chk("data", rxData, 9'h0FF);
		end
		cyc(200);
		bitClks = 16'h0010;
		nineBits <= 1'b1;
		wr(OFS_DIV, 8'h00);
		wr(OFS_CTRL, EN | HS | NB);
		wr(OFS_HOLD, 8'h5A);
		waitRx(base + 2);
		chk("data", rxData, 9'h15A);
		chk("stop", rxStop, 1'b1);
		cyc(40);
		nineBits <= 1'b0;
		wr(OFS_CTRL, HS);
		wr(OFS_HOLD, 8'h81);
		cyc(50);
		chk("oe", serialOe, 1'b0);
		wr(OFS_CTRL, EN | HS);
		waitRx(base + 3);
		chk("data", rxData, 9'h081);
		cyc(40);
		wr(OFS_CTRL, EN | HS | (8'h01 << BIT_SYNC_SEL));
		wr(OFS_HOLD, 8'h42);
		cyc(300);
		chk("frame count", 16'(rxCount), 16'(base + 3));
		chk("oe", serialOe, 1'b0);
		// Data 0x0F: line is high mid-character and would fall if not frozen
		wr(OFS_CTRL, EN | HS);
		wr(OFS_HOLD, 8'h0F);
		cyc(60);
		sleepMode <= 1'b1;
		snap = {7'h00, serialOut};
		cyc(100);
		chk("sleep line", serialOut, snap);
		sleepMode <= 1'b0;
		cyc(10);
		wr(OFS_CTRL, HS);
		cyc(2);
		chk("oe", serialOe, 1'b0);
		rd(OFS_CTRL, v);
		chk("empty", v & SE, SE);
		// Second reset in mid-run: everything back to its reset values
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		chk("flag", bufEmptyFlag, 1'b0);
		chk("irq", txIrq, 1'b0);
		chk("oe", serialOe, 1'b0);
		rd(OFS_CTRL, v);
		chk("ctrl", v, CTRL_RESET);
		rd(OFS_DIV, v);
		chk("divisor", v, 8'h00);
		closeOut();
	end
endmodule
